// ---- src/dmem_defines.svh ----
`ifndef DMEM_DEFINES_SVH
`define DMEM_DEFINES_SVH

`define ADDR_W          8
`define DATA_W          8
`define IND_PORT_ADDR   8'h00
`define MEM_PTR_ADDR    8'h01
`define ACC_ADDR        8'h05
`define SPECIAL_LAST    8'h3F
`define GENERAL_FIRST   8'h40
`define GENERAL_LAST    8'h7F
`define GENERAL_DEPTH   64
`define GENERAL_IDX_W   6
`define PTR_RESET       8'h00
`define ACC_RESET       8'h00
`define READ_UNUSED     8'h00

`endif

// ---- src/dmem_pkg.sv ----
package dmem_pkg;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_WRITE = 3'b001,
    OP_BSET  = 3'b010,
    OP_BCLR  = 3'b011,
    OP_INC   = 3'b100,
    OP_DEC   = 3'b101
  } mem_op_e;

  typedef struct packed {
    mem_op_e    op;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
    logic       rd;
  } mem_req_s;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } acc_wr_s;

endpackage

// ---- src/gp_ram.sv ----
`timescale 1ns/10ps
`include "dmem_defines.svh"

module gp_ram #(
  parameter int DEPTH = `GENERAL_DEPTH,
  parameter int AW    = `GENERAL_IDX_W,
  parameter int DW    = `DATA_W
) (
  input  wire logic          clk_in,
  input  wire logic          we_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  input  wire logic [AW-1:0] raddr_in,
  output logic      [DW-1:0] rdata_out
);

  logic [DW-1:0] mem_q [DEPTH];

  // Contents are volatile: no reset, as for real RAM
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem_q[raddr_in];
  end

endmodule // gp_ram

// ---- src/sfr_core.sv ----
`timescale 1ns/10ps
`include "dmem_defines.svh"

// Memory pointer and accumulator storage
module sfr_core (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       ptr_we_in,
  input  wire logic [7:0] ptr_d_in,
  input  wire logic       acc_we_in,
  input  wire logic [7:0] acc_d_in,
  output logic      [7:0] ptr_q_out,
  output logic      [7:0] acc_q_out
);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_q_out <= `PTR_RESET;
    end else if (ptr_we_in) begin
      ptr_q_out <= ptr_d_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      acc_q_out <= `ACC_RESET;
    end else if (acc_we_in) begin
      acc_q_out <= acc_d_in;
    end
  end

endmodule // sfr_core

// ---- src/data_memory_indirect_access.sv ----
`timescale 1ns/10ps
`include "dmem_defines.svh"

// How it works
// - General area fully readable and writable
// - Bit set/clear keeps other bits
// - Protected special registers ignore writes
// - Unused special addresses read 00H
// - Indirect port redirects to pointer address
// - Indirect reach limited to bank 0
// - Indirect port aimed at itself reads 00H, stores nothing
// - Pointer readable, writable, incrementable, decrementable
// - ALU results captured in accumulator
// - No register-to-register move path
// - 00-3F special, 40-7F general decode
module data_memory_indirect_access (
  input  wire logic             CLK_IN,
  input  wire logic             NRST_IN,
  input  wire dmem_pkg::mem_req_s REQ_IN,
  input  wire dmem_pkg::acc_wr_s  ALU_IN,
  output logic      [7:0]       RDATA_OUT,
  output logic                  RVALID_OUT,
  output logic      [7:0]       ACC_OUT,
  output logic      [7:0]       PTR_OUT
);

  // ----------------------------------------------------------------
  // Address classification
  // ----------------------------------------------------------------
  function automatic logic is_general(input logic [7:0] a);
    return (a >= `GENERAL_FIRST) && (a <= `GENERAL_LAST);
  endfunction

  function automatic logic is_ptr(input logic [7:0] a);
    return a == `MEM_PTR_ADDR;
  endfunction

  function automatic logic is_acc(input logic [7:0] a);
    return a == `ACC_ADDR;
  endfunction

  function automatic logic is_port(input logic [7:0] a);
    return a == `IND_PORT_ADDR;
  endfunction

  // Codes 6 and 7 are not ops; they must never reach a store
  function automatic logic is_modify(input dmem_pkg::mem_op_e op);
    return (op == dmem_pkg::OP_WRITE) || (op == dmem_pkg::OP_BSET) ||
           (op == dmem_pkg::OP_BCLR) || (op == dmem_pkg::OP_INC) ||
           (op == dmem_pkg::OP_DEC);
  endfunction

  // Only the pointer and the accumulator live here; the other special
  // registers belong to other blocks, so this block shows them as zero.
  function automatic logic [7:0] special_value(input logic [7:0] a,
                                               input logic [7:0] ptr,
                                               input logic [7:0] acc);
    logic [7:0] v;
    v = `READ_UNUSED;
    if (is_ptr(a)) begin
      v = ptr;
    end else if (is_acc(a)) begin
      v = acc;
    end
    return v;
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction

  function automatic logic [7:0] apply_op(input dmem_pkg::mem_op_e op,
                                          input logic [7:0] old,
                                          input logic [7:0] wd,
                                          input logic [2:0] b);
    logic [7:0] r;
    r = old;
    unique case (op)
      dmem_pkg::OP_NONE:  r = old;
      dmem_pkg::OP_WRITE: r = wd;
      dmem_pkg::OP_BSET:  r = old | bit_mask(b);
      dmem_pkg::OP_BCLR:  r = old & ~bit_mask(b);
      dmem_pkg::OP_INC:   r = old + 8'h01;
      dmem_pkg::OP_DEC:   r = old - 8'h01;
      default:            r = old;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Decode and storage interface
  logic [7:0] ptr_q;
  logic [7:0] acc_q;
  logic [7:0] ram_rdata;
  logic [7:0] ram_cur;
  logic [7:0] eff_addr;
  logic [7:0] old_val;
  logic [7:0] new_val;
  logic       is_mod;
  logic       ram_we;
  logic       ptr_we;
  logic       acc_mw;
  logic       acc_we;
  logic [7:0] acc_d;

  // Forwarding and read pipeline
  logic       fwd_hit_q;
  logic [7:0] fwd_data_q;
  logic       rd_pend_q;
  logic [7:0] rd_reg_q;
  logic       rd_ram_q;

  // ----------------------------------------------------------------
  // Indirect redirection
  // ----------------------------------------------------------------
  // The pointer is used in full; its value selects only bank 0. A pointer
  // at the port itself resolves to a port that reads 00H and stores nothing.
  always_comb begin
    eff_addr = REQ_IN.addr;
    if (is_port(REQ_IN.addr)) begin
      eff_addr = ptr_q;
    end
  end

  // ----------------------------------------------------------------
  // Read-modify-write source
  // ----------------------------------------------------------------
  // Read-modify-write needs the old value now, so the accumulator and pointer
  // come from flops; general RAM bit ops read the registered RAM data copy.
  always_comb begin
    old_val = special_value(eff_addr, ptr_q, acc_q);
    if (is_general(eff_addr)) begin
      old_val = ram_cur;
    end
  end

  assign is_mod  = is_modify(REQ_IN.op);
  assign new_val = apply_op(REQ_IN.op, old_val, REQ_IN.wdata, REQ_IN.bit_sel);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // All other special addresses drop writes: protected or unused.
  // Addresses above the general area are outside the map and drop too.
  always_comb begin
    ram_we = 1'b0;
    ptr_we = 1'b0;
    acc_mw = 1'b0;
    if (is_mod) begin
      if (is_general(eff_addr)) begin
        ram_we = 1'b1;
      end else if (is_ptr(eff_addr)) begin
        ptr_we = 1'b1;
      end else if (is_acc(eff_addr)) begin
        acc_mw = 1'b1;
      end
      // Any other address: nothing is stored
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Only the accumulator takes ALU results; transfers between two other
  // registers have no path except through it.
  always_comb begin
    acc_we = 1'b0;
    acc_d  = acc_q;
    if (ALU_IN.we) begin
      acc_we = 1'b1;
      acc_d  = ALU_IN.data;
    end else if (acc_mw) begin
      acc_we = 1'b1;
      acc_d  = new_val;
    end
  end

  // ----------------------------------------------------------------
  // Write-to-read forwarding
  // ----------------------------------------------------------------
  // The RAM reads and writes the same byte on one edge and returns the old
  // value, so a bit op right after a modify of that byte would undo it. The
  // last stored byte stands in for it; plain reads still see the byte as it
  // stood before a same-cycle write.
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fwd_hit_q <= 1'b0;
    end else begin
      fwd_hit_q <= ram_we;
    end
  end

  always_ff @(posedge CLK_IN) begin
    fwd_data_q <= new_val;
  end

  assign ram_cur = fwd_hit_q ? fwd_data_q : ram_rdata;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // The RAM holds the general area only, indexed by the low address bits;
  // the decode above keeps every other address away from its write port.
  gp_ram #(
    .DEPTH (`GENERAL_DEPTH),
    .AW    (`GENERAL_IDX_W),
    .DW    (`DATA_W)
  ) u_ram (
    .clk_in    (CLK_IN),
    .we_in     (ram_we),
    .waddr_in  (eff_addr[`GENERAL_IDX_W-1:0]),
    .wdata_in  (new_val),
    .raddr_in  (eff_addr[`GENERAL_IDX_W-1:0]),
    .rdata_out (ram_rdata)
  );

  // Pointer and accumulator keep their reset value until written
  sfr_core u_sfr (
    .clk_in    (CLK_IN),
    .nrst_in   (NRST_IN),
    .ptr_we_in (ptr_we),
    .ptr_d_in  (new_val),
    .acc_we_in (acc_we),
    .acc_d_in  (acc_d),
    .ptr_q_out (ptr_q),
    .acc_q_out (acc_q)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // A read sampled at one edge is classified at that edge and shows on the
  // outputs at the next one, together with the valid pulse. A same-cycle
  // write is not seen by that read.
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= REQ_IN.rd;
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_ram_q <= 1'b0;
    end else begin
      rd_ram_q <= is_general(eff_addr);
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_reg_q <= 8'h00;
    end else begin
      rd_reg_q <= special_value(eff_addr, ptr_q, acc_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Output registered once more so it comes straight from a flop
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RVALID_OUT <= 1'b0;
    end else begin
      RVALID_OUT <= rd_pend_q;
    end
  end

  // Read data holds until the next read so the core may take it late
  // without a second request.
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      RDATA_OUT <= 8'h00;
    end else begin
      if (rd_pend_q) begin
        RDATA_OUT <= rd_ram_q ? ram_rdata : rd_reg_q;
      end
    end
  end

  // Shows the value the accumulator takes at this same edge
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ACC_OUT <= `ACC_RESET;
    end else begin
      ACC_OUT <= acc_d;
    end
  end

  // Shows the value the pointer takes at this same edge
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      PTR_OUT <= `PTR_RESET;
    end else begin
      PTR_OUT <= ptr_we ? new_val : ptr_q;
    end
  end

endmodule // data_memory_indirect_access

// ---- dv/dmem_assertions.sv ----
`timescale 1ns/10ps
module dchk (
  input wire logic               CLK_IN,
  input wire logic               NRST_IN,
  input wire dmem_pkg::mem_req_s REQ_IN,
  input wire dmem_pkg::acc_wr_s  ALU_IN,
  input wire logic [7:0]         RDATA_OUT,
  input wire logic               RVALID_OUT,
  input wire logic [7:0]         ACC_OUT,
  input wire logic [7:0]         PTR_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_z; ##2 RVALID_OUT && RDATA_OUT == 8'h00; endsequence
  sequence s_h; ##1 $stable(ACC_OUT) && $stable(PTR_OUT); endsequence
  property p_lat; REQ_IN.rd |-> ##2 RVALID_OUT; endproperty
  a_lat: assert property (p_lat) else $error("late read");
  property p_un; REQ_IN.rd && REQ_IN.addr inside {[8'h02:8'h04], [8'h06:8'h3F]} |-> s_z;
  endproperty
  a_un: assert property (p_un) else $error("unused");
  property p_ia; REQ_IN.rd && REQ_IN.addr == 8'h00 && (PTR_OUT == 8'h00 || PTR_OUT[7]) |-> s_z;
  endproperty
  a_ia: assert property (p_ia) else $error("port");
  property p_pw; REQ_IN.op == 3'h1 && REQ_IN.addr == 8'h01 |=> PTR_OUT == $past(REQ_IN.wdata);
  endproperty
  a_pw: assert property (p_pw) else $error("ptr");
  property p_in; REQ_IN.op == 3'h4 && REQ_IN.addr == 8'h01 |=> PTR_OUT == $past(PTR_OUT) + 8'h01;
  endproperty
  a_in: assert property (p_in) else $error("inc");
  property p_ac; ALU_IN.we |=> ACC_OUT == $past(ALU_IN.data); endproperty
  a_ac: assert property (p_ac) else $error("acc");
  property p_st; REQ_IN.op == 3'h0 && !ALU_IN.we |-> s_h; endproperty
  a_st: assert property (p_st) else $error("moved");
  property p_ro; REQ_IN.op != 3'h0 && REQ_IN.addr inside {[8'h06:8'h3F]} && !ALU_IN.we |-> s_h;
  endproperty
  a_ro: assert property (p_ro) else $error("protected");
endmodule // dchk
bind data_memory_indirect_access dchk chk_u (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .REQ_IN(REQ_IN),
  .ALU_IN(ALU_IN), .RDATA_OUT(RDATA_OUT), .RVALID_OUT(RVALID_OUT), .ACC_OUT(ACC_OUT),
  .PTR_OUT(PTR_OUT));

// ---- dv/core_drv.sv ----
`timescale 1ns/10ps
module core_drv (
  input  wire logic          clk_in,
  input  wire logic [7:0]    rdata_in,
  input  wire logic          rvalid_in,
  output dmem_pkg::mem_req_s req_out,
  output dmem_pkg::acc_wr_s  alu_out
);
  initial req_out = '0;
  initial alu_out = '0;
  task automatic go(logic [2:0] o, logic [7:0] a, d, logic [2:0] b, logic r);
    @(posedge clk_in);
    req_out <= {o, a, d, b, r};
  endtask
  task automatic idle();
    go(3'h0, 8'h00, 8'h00, 3'h0, 1'b0);
    #1;
  endtask
  task automatic wr(logic [7:0] a, d);
    go(3'h1, a, d, 3'h0, 1'b0);
  endtask
  // Address shown a cycle early so the RAM can fetch the old byte
  task automatic rmw(logic [2:0] o, logic [7:0] a, logic [2:0] b);
    go(3'h0, a, 8'h00, 3'h0, 1'b0);
    go(o, a, 8'h00, b, 1'b0);
    idle();
  endtask
  // Data and valid stand from the second edge after the request is shown
  task automatic rd(logic [7:0] a, output logic [7:0] q, output logic v);
    go(3'h0, a, 8'h00, 3'h0, 1'b1);
    idle();
    @(posedge clk_in);
    #1;
    q = rdata_in;
    v = rvalid_in;
  endtask
  task automatic ld(logic [7:0] d);
    @(posedge clk_in);
    alu_out <= {1'b1, d};
    @(posedge clk_in);
    alu_out <= '0;
    #1;
  endtask
endmodule // core_drv

// ---- dv/test_data_memory_indirect_access.sv ----
`timescale 1ns/10ps
module test_data_memory_indirect_access;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] q, acc, ptr, rdat;
  logic rv;
  int err_total = 0, n_checks = 0, cyc = 0;
  dmem_pkg::mem_req_s req;
  dmem_pkg::acc_wr_s alu;
  data_memory_indirect_access dut_u (.CLK_IN(clk), .NRST_IN(rst_n), .REQ_IN(req),
    .ALU_IN(alu), .RDATA_OUT(rdat), .RVALID_OUT(rv), .ACC_OUT(acc), .PTR_OUT(ptr));
  core_drv core_u (.clk_in(clk), .rdata_in(rdat), .rvalid_in(rv), .req_out(req),
    .alu_out(alu));
  initial forever #5 clk = ~clk;
  task automatic chk(logic [7:0] g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rc(logic [7:0] a, e);
    logic v;
    core_u.rd(a, q, v);
    chk({7'h00, v}, 8'h01);
    chk(q, e);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Run needs about 70 cycles; a hang stops well after that
  always @(posedge clk) begin
    if (++cyc == 1000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic t_gp();
    core_u.wr(8'h40, 8'hA5);
    core_u.wr(8'h7F, 8'h5A);
    core_u.wr(8'h3F, 8'hFF);
    rc(8'h40, 8'hA5);
    rc(8'h7F, 8'h5A);
    rc(8'h3F, 8'h00);
    rc(8'h02, 8'h00);
    core_u.rmw(dmem_pkg::OP_BSET, 8'h40, 3'h1);
    rc(8'h40, 8'hA7);
    core_u.rmw(dmem_pkg::OP_BCLR, 8'h40, 3'h7);
    rc(8'h40, 8'h27);
    $display("t_gp done");
  endtask
  task automatic t_ptr();
    core_u.wr(8'h01, 8'h45);
    core_u.wr(8'h00, 8'h3C);
    core_u.idle();
    chk(ptr, 8'h45);
    rc(8'h45, 8'h3C);
    rc(8'h00, 8'h3C);
    core_u.rmw(dmem_pkg::OP_INC, 8'h01, 3'h0);
    chk(ptr, 8'h46);
    core_u.rmw(dmem_pkg::OP_DEC, 8'h01, 3'h0);
    rc(8'h01, 8'h45);
    core_u.wr(8'h01, 8'h00);
    core_u.wr(8'h00, 8'h77);
    rc(8'h00, 8'h00);
    core_u.wr(8'h01, 8'h80);
    core_u.wr(8'h00, 8'h66);
    rc(8'h00, 8'h00);
    rc(8'h40, 8'h27);
    $display("t_ptr done");
  endtask
  task automatic t_acc();
    core_u.ld(8'h5A);
    chk(acc, 8'h5A);
    rc(8'h05, 8'h5A);
    core_u.wr(8'h05, 8'hC3);
    core_u.idle();
    chk(acc, 8'hC3);
    $display("t_acc done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk(ptr, 8'h00);
    chk(acc, 8'h00);
    t_gp();
    t_ptr();
    t_acc();
    complete_run();
  end
endmodule // test_data_memory_indirect_access
